// [core/smw_ctrl.sv]
// Access sequencer with float, external wait and slow clock waveforms
`timescale 1ns/1ps
`default_nettype none
`include "smw_map.svh"
module smw_ctrl
  import smw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Configuration of the selected chip select
  input wire smw_cfg_t cfg_i,
  input wire logic slow_clk_i,
  // Access request
  input wire smw_req_t req_i,
  output logic req_ready_o,
  output logic busy_o,
  // External memory pins
  input wire logic ext_wait_n_i,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [7:0] chip_sel_n_o,
  // Status
  output logic slow_active_o,
  output logic suspended_o
);
  smw_state_t state, next_state;
  smw_timing_t tim, next_tim;
  logic [6:0] cnt, next_cnt;
  logic [3:0] fcnt, next_fcnt;
  logic wr, next_wr;
  logic [2:0] cs, next_cs;
  smw_cfg_t lcfg, next_lcfg;
  logic rd_n, next_rd_n;
  logic we_n, next_we_n;
  logic [7:0] cs_n, next_cs_n;
  logic last_rd, next_last_rd;
  logic slow_used, next_slow_used;
  logic [1:0] mode, next_mode;
  logic [2:0] gap, next_gap;
  logic [3:0] rd_rise, next_rd_rise;
  logic [3:0] cs_rise, next_cs_rise;
  logic wait_n;
  logic [6:0] s_end, p_end, c_end, cs_s_end, cs_p_end;
  logic in_pulse, last_pulse, frozen;
  logic [3:0] tdf_left;
  logic [3:0] ref_rise;

  smw_wait_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ext_wait_n_i(ext_wait_n_i),
    .ext_wait_n_o(wait_n)
  );

  always_comb begin
    s_end = {1'b0, tim.strobe_setup};
    p_end = 7'(s_end + {1'b0, tim.strobe_pulse});
    cs_s_end = {1'b0, tim.cs_setup};
    cs_p_end = 7'(cs_s_end + {1'b0, tim.cs_pulse});
    c_end = tim.cycle_len;
    in_pulse = (state == SMW_ACCESS) && (cnt >= s_end) && (cnt < p_end);
    last_pulse = in_pulse && (cnt == 7'(p_end - 7'h01));
    frozen = (mode == `SMW_EXW_FROZEN) && in_pulse && !wait_n;
    ref_rise = lcfg.read_ctrl_sel ? rd_rise : cs_rise;
    tdf_left = (ref_rise >= lcfg.tdf_cycles) ? 4'h0 : 4'(lcfg.tdf_cycles - ref_rise);
  end

  always_comb begin
    next_state = state;
    next_tim = tim;
    next_cnt = cnt;
    next_fcnt = fcnt;
    next_wr = wr;
    next_cs = cs;
    next_rd_n = rd_n;
    next_we_n = we_n;
    next_cs_n = cs_n;
    next_last_rd = last_rd;
    next_slow_used = slow_used;
    next_mode = mode;
    next_gap = gap;
    next_rd_rise = rd_rise;
    next_cs_rise = cs_rise;
    next_lcfg = lcfg;
    req_ready_o = 1'b0;
    case (state)
      SMW_IDLE: begin
        req_ready_o = 1'b1;
        if (req_i.valid) begin
          // Idle cycles owed before this request
          next_gap = 3'h0;
          if (last_rd && req_i.write) begin
            next_gap = 3'(next_gap + 3'h1);
          end
          if (slow_used != slow_clk_i) begin
            next_gap = 3'(next_gap + 3'h1);
          end
          if (next_gap != 3'h0) begin
            req_ready_o = 1'b0;
            next_state = SMW_GAP;
            next_slow_used = slow_clk_i;
          end else begin
            next_state = SMW_ACCESS;
            next_cnt = 7'h00;
            next_wr = req_i.write;
            next_cs = req_i.cs;
            next_slow_used = slow_clk_i;
            next_mode = slow_clk_i ? `SMW_EXW_OFF : cfg_i.ext_wait_mode_sel;
            if (slow_clk_i) begin
              // Fixed waveforms latched for the whole transfer
              next_tim = req_i.write ?
                {`SMW_SLOW_WR_SETUP, `SMW_SLOW_WR_PULSE, `SMW_SLOW_CS_WR_SETUP, `SMW_SLOW_CS_WR_PULSE,
                 `SMW_SLOW_WR_CYCLE} :
                {`SMW_SLOW_RD_SETUP, `SMW_SLOW_RD_PULSE, `SMW_SLOW_CS_RD_SETUP, `SMW_SLOW_CS_RD_PULSE,
                 `SMW_SLOW_RD_CYCLE};
            end else begin
              next_tim = req_i.write ? cfg_i.wr : cfg_i.rd;
            end
            // Float settings held with the transfer they belong to
            next_lcfg = cfg_i;
            // Zero setup means the line falls in the first access cycle
            next_rd_n = !(!req_i.write && (next_tim.strobe_setup == 6'h00) && (next_tim.strobe_pulse != 6'h00));
            next_we_n = !(req_i.write && (next_tim.strobe_setup == 6'h00) && (next_tim.strobe_pulse != 6'h00));
            next_cs_n = 8'hff;
            if ((next_tim.cs_setup == 6'h00) && (next_tim.cs_pulse != 6'h00)) begin
              next_cs_n[req_i.cs] = 1'b0;
            end
          end
        end
      end
      SMW_GAP: begin
        next_gap = 3'(gap - 3'h1);
        next_last_rd = 1'b0;
        if (gap == 3'h1) begin
          next_state = SMW_IDLE;
        end
      end
      SMW_ACCESS: begin
        if (!frozen) begin
          if (last_pulse && (mode == `SMW_EXW_READY) && !wait_n) begin
            next_state = SMW_SUSPEND;
          end else begin
            next_cnt = 7'(cnt + 7'h01);
            next_rd_n = !(!wr && (next_cnt >= s_end) && (next_cnt < p_end));
            next_we_n = !(wr && (next_cnt >= s_end) && (next_cnt < p_end));
            next_cs_n = 8'hff;
            if ((next_cnt >= cs_s_end) && (next_cnt < cs_p_end)) begin
              next_cs_n[cs] = 1'b0;
            end
            // Cycles elapsed since each strobe went high
            next_rd_rise = (next_cnt >= p_end) ? 4'(next_cnt - p_end) : 4'h0;
            next_cs_rise = (next_cnt >= cs_p_end) ? 4'(next_cnt - cs_p_end) : 4'h0;
            if (next_cnt >= c_end) begin
              next_rd_n = 1'b1;
              next_we_n = 1'b1;
              next_cs_n = 8'hff;
              next_last_rd = !wr;
              next_state = SMW_IDLE;
              // The idle cycle before the next take counts as a float cycle
              if (!wr && !lcfg.tdf_opt && (tdf_left > 4'h2)) begin
                next_fcnt = 4'(tdf_left - 4'h2);
                next_state = SMW_FLOAT;
              end
            end
          end
        end
      end
      SMW_SUSPEND: begin
        if (wait_n) begin
          next_state = SMW_ACCESS;
          next_cnt = 7'(cnt + 7'h01);
          next_rd_n = !(!wr && (next_cnt < p_end));
          next_we_n = !(wr && (next_cnt < p_end));
        end
      end
      SMW_FLOAT: begin
        next_fcnt = 4'(fcnt - 4'h1);
        if (fcnt == 4'h1) begin
          next_state = SMW_IDLE;
        end
      end
      default: begin
        next_state = SMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= SMW_IDLE;
      tim <= '0;
      cnt <= 7'h00;
      fcnt <= 4'h0;
      wr <= 1'b0;
      cs <= 3'h0;
      rd_n <= 1'b1;
      we_n <= 1'b1;
      cs_n <= 8'hff;
      last_rd <= 1'b0;
      slow_used <= 1'b0;
      mode <= `SMW_EXW_OFF;
      gap <= 3'h0;
      rd_rise <= 4'h0;
      cs_rise <= 4'h0;
      lcfg <= '0;
    end else begin
      state <= next_state;
      tim <= next_tim;
      cnt <= next_cnt;
      fcnt <= next_fcnt;
      wr <= next_wr;
      cs <= next_cs;
      rd_n <= next_rd_n;
      we_n <= next_we_n;
      cs_n <= next_cs_n;
      last_rd <= next_last_rd;
      slow_used <= next_slow_used;
      mode <= next_mode;
      gap <= next_gap;
      rd_rise <= next_rd_rise;
      cs_rise <= next_cs_rise;
      lcfg <= next_lcfg;
    end
  end

  assign read_strobe_n_o = rd_n;
  assign write_strobe_n_o = we_n;
  assign chip_sel_n_o = cs_n;
  assign busy_o = (state != SMW_IDLE);
  assign slow_active_o = slow_used;
  assign suspended_o = (state == SMW_SUSPEND) || frozen;
endmodule
`default_nettype wire

// [core/smw_map.svh]
// Constants for the static memory wait-state control block
`ifndef SMW_MAP_SVH
`define SMW_MAP_SVH

`define SMW_EXW_OFF 2'h0
`define SMW_EXW_FROZEN 2'h2
`define SMW_EXW_READY 2'h3

`define SMW_SLOW_RD_SETUP 6'h01
`define SMW_SLOW_RD_PULSE 6'h01
`define SMW_SLOW_CS_RD_SETUP 6'h00
`define SMW_SLOW_CS_RD_PULSE 6'h02
`define SMW_SLOW_RD_CYCLE 7'h02
`define SMW_SLOW_WR_SETUP 6'h01
`define SMW_SLOW_WR_PULSE 6'h01
`define SMW_SLOW_CS_WR_SETUP 6'h00
`define SMW_SLOW_CS_WR_PULSE 6'h03
`define SMW_SLOW_WR_CYCLE 7'h03

`define SMW_TDF_MAX 4'hf

`endif

// [core/smw_pkg.sv]
// Types for the static memory wait-state control block
package smw_pkg;

  typedef struct packed {
    logic [5:0] strobe_setup;
    logic [5:0] strobe_pulse;
    logic [5:0] cs_setup;
    logic [5:0] cs_pulse;
    logic [6:0] cycle_len;
  } smw_timing_t;

  typedef struct packed {
    smw_timing_t rd;
    smw_timing_t wr;
    logic [1:0] ext_wait_mode_sel;
    logic [3:0] tdf_cycles;
    logic tdf_opt;
    logic read_ctrl_sel;
  } smw_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] cs;
  } smw_req_t;

  typedef enum logic [2:0] {
    SMW_IDLE = 3'b000,
    SMW_ACCESS = 3'b001,
    SMW_SUSPEND = 3'b010,
    SMW_FLOAT = 3'b011,
    SMW_GAP = 3'b100
  } smw_state_t;

endpackage

// [core/smw_wait_sync.sv]
// Two-stage synchroniser for the external wait input
`timescale 1ns/1ps
`default_nettype none
module smw_wait_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Wait pin and synchronised level
  input wire logic ext_wait_n_i,
  output logic ext_wait_n_o
);
  logic stage1;
  logic stage2;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= ext_wait_n_i;
      stage2 <= stage1;
    end
  end

  assign ext_wait_n_o = stage2;
endmodule
`default_nettype wire

// [sim/smw_ctrl_checker.sv]
// Assertion checker for the wait-state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "smw_map.svh"
module smw_ctrl_checker
  import smw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Watched ports
  input wire smw_cfg_t cfg_i,
  input wire smw_req_t req_i,
  input wire logic req_ready_o,
  input wire logic busy_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic [7:0] chip_sel_n_o,
  input wire logic slow_active_o,
  input wire logic suspended_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  idle_pins_a: assert property (!busy_o |-> read_strobe_n_o && write_strobe_n_o)
    else $error("strobe low while idle");
  one_select_a: assert property ($onehot0(~chip_sel_n_o))
    else $error("more than one chip select low");
  strobe_excl_a: assert property (!(!read_strobe_n_o && !write_strobe_n_o))
    else $error("both strobes low");
  take_busy_a: assert property (req_i.valid && req_ready_o |=> busy_o)
    else $error("no busy after take");
  busy_refuse_a: assert property (busy_o |-> !req_ready_o)
    else $error("ready while busy");
  wait_off_a: assert property (req_i.valid && req_ready_o && cfg_i.ext_wait_mode_sel == `SMW_EXW_OFF
    |=> !suspended_o [*6])
    else $error("suspend with wait disabled");
  slow_nowait_a: assert property (slow_active_o |-> !suspended_o)
    else $error("suspend in slow clock");
  susp_pulse_a: assert property (suspended_o |-> !read_strobe_n_o || !write_strobe_n_o)
    else $error("suspend outside pulse");
  freeze_hold_a: assert property (suspended_o && $past(suspended_o)
    |-> $stable({read_strobe_n_o, write_strobe_n_o, chip_sel_n_o}))
    else $error("pins moved while held");
  slow_rd_a: assert property (slow_active_o && $fell(read_strobe_n_o) |=> $rose(read_strobe_n_o))
    else $error("slow read pulse not one cycle");
  cover property (suspended_o && cfg_i.ext_wait_mode_sel == `SMW_EXW_FROZEN);
  cover property (slow_active_o && busy_o);
  cover property (req_i.valid && !req_ready_o && !busy_o);
endmodule
bind smw_ctrl smw_ctrl_checker i_smw_ctrl_checker (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg_i), .req_i(req_i),
  .req_ready_o(req_ready_o), .busy_o(busy_o), .read_strobe_n_o(read_strobe_n_o),
  .write_strobe_n_o(write_strobe_n_o), .chip_sel_n_o(chip_sel_n_o), .slow_active_o(slow_active_o),
  .suspended_o(suspended_o));
`default_nettype wire

// [sim/smw_ext_mem.sv]
// External device model answering with the active-low wait
`timescale 1ns/1ps
`default_nettype none
module smw_ext_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Behaviour chosen by the bench
  input wire logic [3:0] lat_i,
  input wire logic [3:0] hold_i,
  // Pins
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  output logic ext_wait_n_o
);
  logic act;
  logic act_q;
  logic [5:0] cnt;
  assign act = !read_strobe_n_i || !write_strobe_n_i;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_q <= 1'b0;
      cnt <= 6'h00;
    end else begin
      act_q <= act;
      cnt <= (act && !act_q) ? 6'h01 : ((cnt != 6'h3f && cnt != 6'h00) ? cnt + 6'h01 : cnt);
    end
  end
  // Low for hold_i cycles after lat_i; pull-up level otherwise
  assign ext_wait_n_o = !(cnt > {2'h0, lat_i} && cnt <= {2'h0, lat_i} + {2'h0, hold_i});
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the wait-state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "smw_map.svh"
module tb;
  import smw_pkg::*;
  localparam smw_timing_t TM = '{6'h01, 6'h06, 6'h00, 6'h08, 7'h09};
  localparam smw_req_t RD = '{1'h1, 1'h0, 3'h2};
  localparam smw_req_t WR = '{1'h1, 1'h1, 3'h2};
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic slow_clk_i = 1'b0;
  smw_cfg_t cfg_i = '{TM, TM, `SMW_EXW_OFF, 4'h0, 1'h1, 1'h1};
  smw_req_t req_i = '0;
  logic req_ready_o, busy_o, ext_wait_n, read_strobe_n_o, write_strobe_n_o, slow_active_o, suspended_o;
  logic [7:0] chip_sel_n_o;
  logic [3:0] lat = 4'h0;
  logic [3:0] hold = 4'h0;
  int err_total = 0;
  int n_checks = 0;
  int wt, rl, wl, cl, bl;
  initial forever #4 clk_i = ~clk_i;
  smw_ctrl i_smw_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg_i), .slow_clk_i(slow_clk_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .busy_o(busy_o), .ext_wait_n_i(ext_wait_n), .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o), .chip_sel_n_o(chip_sel_n_o), .slow_active_o(slow_active_o),
    .suspended_o(suspended_o));
  smw_ext_mem i_smw_ext_mem (.clk_i(clk_i), .nrst_i(nrst_i), .lat_i(lat), .hold_i(hold),
    .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o), .ext_wait_n_o(ext_wait_n));
  function automatic smw_cfg_t cf(input logic [1:0] m, input logic [3:0] t, input logic o, input logic s);
    return '{TM, TM, m, t, o, s};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Drive one request from a rising edge, wait for the take, count busy cycles mid-cycle
  task automatic xfer(input smw_req_t r, input smw_cfg_t c, input logic s, input logic [3:0] lt, hd,
    input logic drop);
    int i;
    {wt, rl, wl, cl, bl} = '0;
    req_i <= r;
    cfg_i <= c;
    slow_clk_i <= s;
    lat <= lt;
    hold <= hd;
    do begin
      @(negedge clk_i);
      wt++;
    end while (req_ready_o !== 1'b1 && wt < 50);
    @(posedge clk_i);
    req_i <= '0;
    if (drop) begin
      slow_clk_i <= 1'b0;
    end
    for (i = 0; i < 200 && wt < 50; i++) begin
      @(negedge clk_i);
      if (busy_o === 1'b0) break;
      bl++;
      rl += int'(read_strobe_n_o === 1'b0);
      wl += int'(write_strobe_n_o === 1'b0);
      cl += int'(chip_sel_n_o === 8'hfb);
    end
    if (i == 200 || wt >= 50) begin
      err_total++;
      summarize();
    end
    @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    xfer(RD, cf(`SMW_EXW_OFF, 4'h0, 1'h1, 1'h1), 1'b0, 4'h0, 4'ha, 1'b0);
    chk(wt, 1);
    chk(rl, 6);
    chk(cl, 8);
    chk(bl, 9);
    xfer(WR, cf(`SMW_EXW_READY, 4'h0, 1'h1, 1'h1), 1'b0, 4'h0, 4'h0, 1'b0);
    chk(wt, 3);
    chk(wl, 6);
    xfer(RD, cf(`SMW_EXW_READY, 4'h0, 1'h1, 1'h1), 1'b0, 4'h0, 4'ha, 1'b0);
    chk(rl, 14);
    chk(cl - rl, 2);
    chk(bl, 17);
    xfer(RD, cf(`SMW_EXW_FROZEN, 4'h0, 1'h1, 1'h1), 1'b0, 4'h0, 4'h1, 1'b0);
    chk(rl, 7);
    chk(bl, 10);
    xfer(RD, cf(`SMW_EXW_READY, 4'h0, 1'h1, 1'h1), 1'b0, 4'h0, 4'h1, 1'b0);
    chk(rl, 6);
    chk(bl, 9);
    xfer(RD, cf(`SMW_EXW_FROZEN, 4'h0, 1'h1, 1'h1), 1'b0, 4'h3, 4'h2, 1'b0);
    chk(rl, 6);
    chk(bl, 9);
    xfer(RD, cf(`SMW_EXW_OFF, 4'h0, 1'h1, 1'h1), 1'b1, 4'h0, 4'h0, 1'b0);
    chk(wt, 3);
    chk(rl, 1);
    chk(cl, 2);
    chk(slow_active_o, 1);
    xfer(WR, cf(`SMW_EXW_OFF, 4'h0, 1'h1, 1'h1), 1'b1, 4'h0, 4'h0, 1'b1);
    chk(wt, 3);
    chk(wl, 1);
    chk(cl, 3);
    xfer(RD, cf(`SMW_EXW_OFF, 4'hf, 1'h0, 1'h1), 1'b0, 4'h0, 4'h0, 1'b0);
    chk(wt, 3);
    chk(rl, 6);
    chk(bl, 21);
    chk(slow_active_o, 0);
    xfer(RD, cf(`SMW_EXW_OFF, 4'hf, 1'h0, 1'h0), 1'b0, 4'h0, 4'h0, 1'b0);
    chk(bl, 22);
    xfer(RD, cf(`SMW_EXW_OFF, 4'h2, 1'h0, 1'h1), 1'b0, 4'h0, 4'h0, 1'b0);
    chk(bl, 9);
    xfer(RD, cf(`SMW_EXW_OFF, 4'hf, 1'h1, 1'h1), 1'b0, 4'h0, 4'h0, 1'b0);
    chk(bl, 9);
    summarize();
  end
endmodule
`default_nettype wire
